/* File: include/lpt_pkg.sv */
// Shared constants of the link register bank: offsets, fields, resets, counts.
// Assumes a 125 MHz system clock and a 9-bit byte address.
package lpt_pkg;
   localparam int          ADDR_W       = 9;
   localparam logic [8:0]  OFS_PHY_CTRL = 9'h0ec;
   localparam logic [8:0]  OFS_CYC_TIME = 9'h0f0;
   localparam logic [8:0]  OFS_FILT_SET = 9'h100;
   localparam logic [8:0]  OFS_FILT_CLR = 9'h104;
   localparam logic [8:0]  OFS_LINK_CFG = 9'h110;
   // Phy access word
   localparam int          DONE_BIT     = 31;
   localparam int          RADDR_LSB    = 24;
   localparam int          RDATA_LSB    = 16;
   localparam int          RD_REQ_BIT   = 15;
   localparam int          WR_REQ_BIT   = 14;
   localparam int          TADDR_LSB    = 8;
   localparam int          WDATA_LSB    = 0;
   // Cycle timer word
   localparam int          SEC_LSB      = 25;
   localparam int          CYC_LSB      = 12;
   localparam logic [12:0] CYC_LAST     = 13'h1f3f;
   localparam logic [11:0] TICK_LAST    = 12'hbff;
   localparam logic [31:0] TIMER_RST    = 32'h0000_0000;
   // Tick rate against system clock, both in kHz
   localparam int          TICK_KHZ     = 24576;
   localparam int          CLK_KHZ      = 125000;
   // Filter word and link config
   localparam int          ANY_BUS_BIT  = 31;
   localparam logic [31:0] FILT_RST     = 32'h0000_0000;
   localparam logic [5:0]  NODE_FIRST   = 6'h20;
   localparam logic [5:0]  NODE_BCAST   = 6'h3f;
   localparam int          CFG_MASTER   = 0;
   localparam int          CFG_RUN      = 1;
   localparam int          CFG_EXT8K    = 2;
   localparam logic [2:0]  CFG_RST      = 3'h0;
endpackage : lpt_pkg

/* File: verilog/lpt_phy_access.sv */
// Phy register access: control word, request launch, returned transfer capture.
// Assumes the phy link accepts a request when valid and ready are both high.
`timescale 1ns/10ps
module lpt_phy_access
(
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        sw_wr_in,
   input  wire logic [31:0] sw_wdata_in,
   output logic      [31:0] word_out,
   output logic             req_valid_out,
   output logic             req_write_out,
   output logic      [3:0]  req_index_out,
   output logic      [7:0]  req_value_out,
   input  wire logic        req_ready_in,
   input  wire logic        xfer_in,
   input  wire logic [3:0]  xfer_index_in,
   input  wire logic [7:0]  xfer_value_in
);
   logic       rd_req_r;
   logic       wr_req_r;
   logic       done_r;
   logic [3:0] ret_idx_r;
   logic [7:0] ret_val_r;
   logic [3:0] tgt_idx_r;
   logic [7:0] out_val_r;
   logic       sw_rd;
   logic       sw_wrq;
   logic       sent;

   assign sw_rd  = sw_wr_in & sw_wdata_in[lpt_pkg::RD_REQ_BIT];
   assign sw_wrq = sw_wr_in & sw_wdata_in[lpt_pkg::WR_REQ_BIT];
   assign sent   = req_valid_out & req_ready_in;

   // Software set beats the hardware clear of the same cycle
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         rd_req_r <= 1'b0;
         wr_req_r <= 1'b0;
      end
      else
      begin
         rd_req_r <= sw_rd | (rd_req_r & ~sent);
         wr_req_r <= sw_wrq | (wr_req_r & ~sent);
      end
   end

   // Arrival beats the clear caused by a new request
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         done_r <= 1'b0;
      else if (xfer_in)
         done_r <= 1'b1;
      else if (sw_rd | sw_wrq)
         done_r <= 1'b0;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         ret_idx_r <= 4'h0;
         ret_val_r <= 8'h00;
      end
      else if (xfer_in)
      begin
         ret_idx_r <= xfer_index_in;
         ret_val_r <= xfer_value_in;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         tgt_idx_r <= 4'h0;
         out_val_r <= 8'h00;
      end
      else if (sw_wr_in)
      begin
         tgt_idx_r <= sw_wdata_in[lpt_pkg::TADDR_LSB +: 4];
         out_val_r <= sw_wdata_in[lpt_pkg::WDATA_LSB +: 8];
      end
   end

   // Read wins if software breaks exclusivity
   assign req_valid_out = rd_req_r | wr_req_r;
   assign req_write_out = wr_req_r & ~rd_req_r;
   assign req_index_out = tgt_idx_r;
   assign req_value_out = out_val_r;
   assign word_out      = {done_r, 3'h0, ret_idx_r, ret_val_r, rd_req_r, wr_req_r,
                           2'h0, tgt_idx_r, out_val_r};
endmodule : lpt_phy_access

/* File: verilog/lpt_cycle_timer.sv */
// Isochronous cycle timer with cycle start load and transmit.
// Assumes the external 8 kHz tick is an asynchronous pin.
`timescale 1ns/10ps
module lpt_cycle_timer
(
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        master_in,
   input  wire logic        run_in,
   input  wire logic        ext_sel_in,
   input  wire logic        ext_tick_in,
   input  wire logic        sw_wr_in,
   input  wire logic [31:0] sw_wdata_in,
   input  wire logic        cs_rx_in,
   input  wire logic [31:0] cs_rx_data_in,
   output logic      [31:0] time_out,
   output logic             cs_tx_out,
   output logic      [31:0] cs_tx_data_out
);
   localparam logic [17:0] INC = 18'(lpt_pkg::TICK_KHZ);
   localparam logic [17:0] MOD = 18'(lpt_pkg::CLK_KHZ);
   logic [17:0] acc_r;
   logic [17:0] acc_sum;
   logic [2:0]  ext_sync_r;
   logic [6:0]  sec_r;
   logic [12:0] cyc_r;
   logic [11:0] tick_r;
   logic        tick;
   logic        ext_edge;
   logic        roll;

   // Fractional divider: 24.576 MHz ticks out of 125 MHz
   assign acc_sum = acc_r + INC;
   assign tick    = acc_sum >= MOD;
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         acc_r <= 18'h0;
      else
         acc_r <= tick ? acc_sum - MOD : acc_sum;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         ext_sync_r <= 3'h0;
      else
         ext_sync_r <= {ext_sync_r[1:0], ext_tick_in};
   end
   assign ext_edge = ext_sel_in & ext_sync_r[1] & ~ext_sync_r[2];

   // In external mode only the external tick ends a cycle
   assign roll = ext_sel_in ? ext_edge : (run_in & tick & tick_r == lpt_pkg::TICK_LAST);

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         {sec_r, cyc_r, tick_r} <= lpt_pkg::TIMER_RST;
      else if (sw_wr_in)
         {sec_r, cyc_r, tick_r} <= sw_wdata_in;
      else if (cs_rx_in & ~master_in)
         {sec_r, cyc_r, tick_r} <= cs_rx_data_in;
      else if (roll)
      begin
         tick_r <= 12'h0;
         cyc_r  <= (cyc_r == lpt_pkg::CYC_LAST) ? 13'h0 : cyc_r + 13'h1;
         if (cyc_r == lpt_pkg::CYC_LAST)
            sec_r <= sec_r + 7'h1;
      end
      else if (run_in & tick & tick_r != lpt_pkg::TICK_LAST)
         tick_r <= tick_r + 12'h1;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         cs_tx_out <= 1'b0;
      else
         cs_tx_out <= master_in & roll & ~sw_wr_in;
   end

   assign time_out       = {sec_r, cyc_r, tick_r};
   assign cs_tx_data_out = time_out;
endmodule : lpt_cycle_timer

/* File: verilog/lpt_link_regs.sv */
// Link register bank top: register port, phy access, cycle timer, upper source filter.
// Assumes a single-cycle register master on the same clock and same-clock packet inputs.
`timescale 1ns/10ps
// Behaviour
// - Setting read or write request clears the read-complete flag.
// - A register transfer from the phy sets the read-complete flag.
// - Returned index holds the address of the latest phy transfer.
// - Returned value holds the eight data bits of the latest transfer.
// - Read request launches a phy read, cleared by hardware once sent.
// - Write request launches a phy write, cleared by hardware once sent.
// - Target index addresses the phy register for reads and writes.
// - Outgoing value is write data and is ignored for reads.
// - As cycle master, cycle start packets carry the current timer value.
// - Not master, an incoming cycle start loads the timer unless software writes the timer in the same cycle.
// - Without cycle starts the timer may keep counting when enabled.
// - Seconds field counts cycle rollovers modulo 128.
// - Cycle field counts tick rollovers modulo 8000.
// - Tick field counts 24.576 MHz clocks modulo 3072.
// - External 8 kHz mode forces tick field to zero each tick.
// - Source node of packets for physical or request context is examined.
// - Clear filter bit means no acknowledge and no queueing.
// - Per-node comparison applies only to sources on the local bus.
// - Remote-bus requests are refused unless any-bus accept is set.
// - Upper word bit n accepts local node n plus 32; here bit 31 is any-bus accept and node 63 never passes the per-node check.
// - Upper filter word reads at set and clear alias, resets to zero.
// - Node id is local bus id concatenated with local node id.
module lpt_link_regs
(
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic [8:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rdata_out,
   output logic             phy_req_valid_out,
   output logic             phy_req_write_out,
   output logic      [3:0]  phy_req_index_out,
   output logic      [7:0]  phy_req_value_out,
   input  wire logic        phy_req_ready_in,
   input  wire logic        phy_xfer_in,
   input  wire logic [3:0]  phy_xfer_index_in,
   input  wire logic [7:0]  phy_xfer_value_in,
   input  wire logic        ext_cycle_tick_in,
   input  wire logic        cs_rx_in,
   input  wire logic [31:0] cs_rx_data_in,
   output logic             cs_tx_out,
   output logic      [31:0] cs_tx_data_out,
   input  wire logic [9:0]  local_bus_id_in,
   input  wire logic [5:0]  local_node_id_in,
   input  wire logic        rx_valid_in,
   input  wire logic        rx_ctx_hit_in,
   input  wire logic [15:0] rx_src_id_in,
   input  wire logic        low_filter_accept_in,
   output logic             rx_done_out,
   output logic             rx_accept_out
);
   logic [31:0] filt_r;
   logic [2:0]  cfg_r;
   logic [31:0] rdata_r;
   logic        rx_done_r;
   logic        rx_accept_r;
   logic [31:0] phy_word;
   logic [31:0] time_word;
   logic        wr_phy;
   logic        wr_time;
   logic        wr_set;
   logic        wr_clr;
   logic [15:0] own_id;
   logic [9:0]  src_bus;
   logic [5:0]  src_node;
   logic        is_local;
   logic        node_hit;
   logic        accept;

   assign wr_phy  = wr_in & addr_in == lpt_pkg::OFS_PHY_CTRL;
   assign wr_time = wr_in & addr_in == lpt_pkg::OFS_CYC_TIME;
   assign wr_set  = wr_in & addr_in == lpt_pkg::OFS_FILT_SET;
   assign wr_clr  = wr_in & addr_in == lpt_pkg::OFS_FILT_CLR;

   lpt_phy_access u_phy
   (
      .clk_in        (clk_in),
      .reset_in      (reset_in),
      .sw_wr_in      (wr_phy),
      .sw_wdata_in   (wdata_in),
      .word_out      (phy_word),
      .req_valid_out (phy_req_valid_out),
      .req_write_out (phy_req_write_out),
      .req_index_out (phy_req_index_out),
      .req_value_out (phy_req_value_out),
      .req_ready_in  (phy_req_ready_in),
      .xfer_in       (phy_xfer_in),
      .xfer_index_in (phy_xfer_index_in),
      .xfer_value_in (phy_xfer_value_in)
   );

   lpt_cycle_timer u_timer
   (
      .clk_in         (clk_in),
      .reset_in       (reset_in),
      .master_in      (cfg_r[lpt_pkg::CFG_MASTER]),
      .run_in         (cfg_r[lpt_pkg::CFG_RUN]),
      .ext_sel_in     (cfg_r[lpt_pkg::CFG_EXT8K]),
      .ext_tick_in    (ext_cycle_tick_in),
      .sw_wr_in       (wr_time),
      .sw_wdata_in    (wdata_in),
      .cs_rx_in       (cs_rx_in),
      .cs_rx_data_in  (cs_rx_data_in),
      .time_out       (time_word),
      .cs_tx_out      (cs_tx_out),
      .cs_tx_data_out (cs_tx_data_out)
   );

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         cfg_r <= lpt_pkg::CFG_RST;
      else if (wr_in & addr_in == lpt_pkg::OFS_LINK_CFG)
         cfg_r <= wdata_in[2:0];
   end

   // Both aliases hit in one cycle cannot happen: strobes are single
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         filt_r <= lpt_pkg::FILT_RST;
      else if (wr_set)
         filt_r <= filt_r | wdata_in;
      else if (wr_clr)
         filt_r <= filt_r & ~wdata_in;
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         rdata_r <= 32'h0;
      else if (rd_in)
         unique case (addr_in)
            lpt_pkg::OFS_PHY_CTRL: rdata_r <= phy_word;
            lpt_pkg::OFS_CYC_TIME: rdata_r <= time_word;
            lpt_pkg::OFS_FILT_SET,
            lpt_pkg::OFS_FILT_CLR: rdata_r <= filt_r;
            lpt_pkg::OFS_LINK_CFG: rdata_r <= {29'h0, cfg_r};
            default:               rdata_r <= 32'h0;
         endcase
      else
         rdata_r <= 32'h0;
   end
   assign rdata_out = rdata_r;

   // Source filter
   assign own_id   = {local_bus_id_in, local_node_id_in};
   assign src_bus  = rx_src_id_in[15:6];
   assign src_node = rx_src_id_in[5:0];
   assign is_local = src_bus == own_id[15:6];
   // Nodes below 32 belong to the lower word, kept outside this block
   assign node_hit = (src_node == lpt_pkg::NODE_BCAST) ? 1'b0 :
                     (src_node >= lpt_pkg::NODE_FIRST) ? filt_r[src_node[4:0]] :
                     low_filter_accept_in;
   assign accept   = ~rx_ctx_hit_in ? 1'b1 :
                     is_local ? node_hit :
                     filt_r[lpt_pkg::ANY_BUS_BIT];

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         rx_done_r   <= 1'b0;
         rx_accept_r <= 1'b0;
      end
      else
      begin
         rx_done_r   <= rx_valid_in;
         rx_accept_r <= rx_valid_in & accept;
      end
   end
   assign rx_done_out   = rx_done_r;
   assign rx_accept_out = rx_accept_r;

   // Checks
   sequence s_req_set;
      wr_phy && (wdata_in[lpt_pkg::RD_REQ_BIT] || wdata_in[lpt_pkg::WR_REQ_BIT]);
   endsequence

   sequence s_sent;
      phy_req_valid_out && phy_req_ready_in && !wr_phy;
   endsequence

   property p_done_clear;
      @(posedge clk_in) disable iff (reset_in)
      s_req_set and !phy_xfer_in |=> !phy_word[lpt_pkg::DONE_BIT]
         until_with (phy_xfer_in || (wr_phy && !(wdata_in[15] || wdata_in[14])));
   endproperty
   a_done_clear: assert property (p_done_clear)
      else $error("read-complete not cleared by new request");

   property p_done_set;
      @(posedge clk_in) disable iff (reset_in)
      phy_xfer_in |=> phy_word[lpt_pkg::DONE_BIT]
         && phy_word[lpt_pkg::RADDR_LSB +: 4] == $past(phy_xfer_index_in)
         && phy_word[lpt_pkg::RDATA_LSB +: 8] == $past(phy_xfer_value_in);
   endproperty
   a_done_set: assert property (p_done_set)
      else $error("returned transfer not captured");

   property p_rd_sent;
      @(posedge clk_in) disable iff (reset_in)
      s_sent ##0 !phy_req_write_out |=> !phy_word[lpt_pkg::RD_REQ_BIT];
   endproperty
   a_rd_sent: assert property (p_rd_sent)
      else $error("read request not cleared after send");

   property p_wr_sent;
      @(posedge clk_in) disable iff (reset_in)
      s_sent ##0 phy_req_write_out |=> !phy_word[lpt_pkg::WR_REQ_BIT];
   endproperty
   a_wr_sent: assert property (p_wr_sent)
      else $error("write request not cleared after send");

   property p_req_launch;
      @(posedge clk_in) disable iff (reset_in)
      s_req_set |=> phy_req_valid_out
         && phy_req_index_out == $past(wdata_in[lpt_pkg::TADDR_LSB +: 4])
         && phy_req_value_out == $past(wdata_in[lpt_pkg::WDATA_LSB +: 8]);
   endproperty
   a_req_launch: assert property (p_req_launch)
      else $error("phy request does not carry programmed index and value");

   property p_timer_range;
      @(posedge clk_in) disable iff (reset_in)
      $changed(time_word) && !$past(wr_time) && !$past(cs_rx_in) |->
         time_word[11:0] <= lpt_pkg::TICK_LAST && time_word[24:12] <= lpt_pkg::CYC_LAST;
   endproperty
   a_timer_range: assert property (p_timer_range)
      else $error("cycle timer field beyond its modulus");

   property p_cs_load;
      @(posedge clk_in) disable iff (reset_in)
      cs_rx_in && !wr_time && !cfg_r[lpt_pkg::CFG_MASTER] |=> time_word == $past(cs_rx_data_in);
   endproperty
   a_cs_load: assert property (p_cs_load)
      else $error("cycle start did not load timer");

   property p_cs_tx;
      @(posedge clk_in) disable iff (reset_in)
      cs_tx_out |-> cfg_r[lpt_pkg::CFG_MASTER] && cs_tx_data_out == time_word
         && time_word[11:0] == 12'h0;
   endproperty
   a_cs_tx: assert property (p_cs_tx)
      else $error("cycle start sent with wrong value or role");

   property p_local_reject;
      @(posedge clk_in) disable iff (reset_in)
      rx_valid_in && rx_ctx_hit_in && is_local && src_node >= lpt_pkg::NODE_FIRST
         && !filt_r[src_node[4:0]] |=> rx_done_out && !rx_accept_out;
   endproperty
   a_local_reject: assert property (p_local_reject)
      else $error("packet from unenabled local node accepted");

   property p_remote;
      @(posedge clk_in) disable iff (reset_in)
      rx_valid_in && rx_ctx_hit_in && !is_local |=>
         rx_accept_out == $past(filt_r[lpt_pkg::ANY_BUS_BIT]);
   endproperty
   a_remote: assert property (p_remote)
      else $error("remote bus packet filtering wrong");

   property p_filt_set;
      @(posedge clk_in) disable iff (reset_in)
      wr_set |=> (filt_r & $past(wdata_in)) == $past(wdata_in)
         && (filt_r & ~$past(wdata_in)) == ($past(filt_r) & ~$past(wdata_in));
   endproperty
   a_filt_set: assert property (p_filt_set)
      else $error("set alias write wrong");

   property p_filt_read;
      @(posedge clk_in) disable iff (reset_in)
      rd_in && (addr_in == lpt_pkg::OFS_FILT_SET || addr_in == lpt_pkg::OFS_FILT_CLR)
         |=> rdata_out == $past(filt_r);
   endproperty
   a_filt_read: assert property (p_filt_read)
      else $error("filter alias read wrong");

   property p_filt_clr;
      @(posedge clk_in) disable iff (reset_in)
      wr_clr |=> (filt_r & $past(wdata_in)) == 32'h0
         && (filt_r | $past(wdata_in)) == ($past(filt_r) | $past(wdata_in));
   endproperty
   a_filt_clr: assert property (p_filt_clr)
      else $error("clear alias write wrong");

   property p_rdata_idle;
      @(posedge clk_in) disable iff (reset_in)
      !rd_in |=> rdata_out == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside a read");

   property p_rx_quiet;
      @(posedge clk_in) disable iff (reset_in)
      !rx_valid_in |=> !rx_done_out && !rx_accept_out;
   endproperty
   a_rx_quiet: assert property (p_rx_quiet)
      else $error("filter verdict without a packet");

   // Index must not move while the phy still waits to take it
   property p_req_hold;
      @(posedge clk_in) disable iff (reset_in)
      phy_req_valid_out && !phy_req_ready_in && !wr_phy |=>
         phy_req_valid_out && $stable(phy_req_index_out);
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("phy request dropped before it was taken");

   property p_tick_roll;
      @(posedge clk_in) disable iff (reset_in)
      time_word[11:0] == lpt_pkg::TICK_LAST && !wr_time && !cs_rx_in |=>
         time_word[11:0] == lpt_pkg::TICK_LAST || time_word[11:0] == 12'h0;
   endproperty
   a_tick_roll: assert property (p_tick_roll)
      else $error("tick field did not wrap to zero");

   // Full wrap of cycle field carries into seconds
   property p_cyc_wrap;
      @(posedge clk_in) disable iff (reset_in)
      time_word[11:0] == 12'h0 && $past(time_word[11:0]) == lpt_pkg::TICK_LAST
         && $past(time_word[24:12]) == lpt_pkg::CYC_LAST
         && !$past(wr_time) && !$past(cs_rx_in) |->
         time_word[24:12] == 13'h0
         && time_word[31:25] == $past(time_word[31:25]) + 7'h1;
   endproperty
   a_cyc_wrap: assert property (p_cyc_wrap)
      else $error("cycle wrap did not carry into seconds");
endmodule : lpt_link_regs

/* File: verif/lpt_phy_model.sv */
// Behavioural physical-layer register file on the far side of the link.
// Assumes requests held until ready; reads answer a few cycles after acceptance.
`timescale 1ns/10ps
module lpt_phy_model
#(
   parameter int DELAY = 2
)
(
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        req_valid_in,
   input  wire logic        req_write_in,
   input  wire logic [3:0]  req_index_in,
   input  wire logic [7:0]  req_value_in,
   output logic             ready_out,
   output logic             xfer_out,
   output logic      [3:0]  xfer_index_out,
   output logic      [7:0]  xfer_value_out
);
   logic [7:0] mem_r [16];
   logic [3:0] wait_r;
   logic [2:0] ret_r;
   logic [3:0] idx_r;

   // Slow ready on purpose, so the request must hold for several cycles
   always_ff @(posedge clk_in)
   begin
      ready_out <= 1'b0;
      xfer_out  <= 1'b0;
      if (reset_in)
      begin
         wait_r         <= 4'h0;
         ret_r          <= 3'h0;
         xfer_index_out <= 4'h0;
         xfer_value_out <= 8'h00;
         for (int i = 0; i < 16; i++) mem_r[i] <= 8'h40 + 8'(i);
      end
      else
      begin
         if (req_valid_in && ready_out)
         begin
            wait_r <= 4'h0;
            if (req_write_in) mem_r[req_index_in] <= req_value_in;
            else
            begin
               ret_r <= 3'h4;
               idx_r <= req_index_in;
            end
         end
         else if (req_valid_in)
         begin
            wait_r    <= wait_r + 4'h1;
            ready_out <= (wait_r == 4'(DELAY));
         end
         // Outside a transfer the data lines toggle, so stale values never match
         if (ret_r == 3'h1)
         begin
            xfer_out       <= 1'b1;
            xfer_index_out <= idx_r;
            xfer_value_out <= mem_r[idx_r];
         end
         else
         begin
            xfer_index_out <= ~xfer_index_out;
            xfer_value_out <= ~xfer_value_out;
         end
         if (ret_r != 3'h0) ret_r <= ret_r - 3'h1;
      end
   end
endmodule : lpt_phy_model

/* File: verif/lpt_link_regs_tb.sv */
// Self-checking bench of the link register bank with a phy partner model.
// Assumes single-cycle register strobes and same-clock packet inputs.
`timescale 1ns/10ps
module lpt_link_regs_tb;
   logic        clk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic [8:0]  addr = 9'h000;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata_out;
   logic        pv, pw, pready, pxfer;
   logic [3:0]  pidx, xidx;
   logic [7:0]  pval, xval;
   logic        ext_tick = 1'b0;
   logic        cs_rx = 1'b0;
   logic [31:0] cs_rx_data = 32'h0;
   logic        cs_tx_out;
   logic [31:0] cs_tx_data_out;
   logic        rx_valid = 1'b0;
   logic        rx_hit = 1'b0;
   logic [15:0] rx_src = 16'h0;
   logic        low_accept = 1'b1;
   logic        rx_done_out, rx_accept_out;
   logic [31:0] rdat;
   int          err_count = 0;
   int          check_count = 0;

   always #4 clk_in = ~clk_in;

   lpt_link_regs lpt_link_regs_i (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata_out),
      .phy_req_valid_out(pv), .phy_req_write_out(pw), .phy_req_index_out(pidx),
      .phy_req_value_out(pval), .phy_req_ready_in(pready), .phy_xfer_in(pxfer),
      .phy_xfer_index_in(xidx), .phy_xfer_value_in(xval), .ext_cycle_tick_in(ext_tick),
      .cs_rx_in(cs_rx), .cs_rx_data_in(cs_rx_data), .cs_tx_out(cs_tx_out),
      .cs_tx_data_out(cs_tx_data_out), .local_bus_id_in(10'h003),
      .local_node_id_in(6'h01), .rx_valid_in(rx_valid), .rx_ctx_hit_in(rx_hit),
      .rx_src_id_in(rx_src), .low_filter_accept_in(low_accept),
      .rx_done_out(rx_done_out), .rx_accept_out(rx_accept_out));

   lpt_phy_model lpt_phy_model_i (.clk_in(clk_in), .reset_in(reset_in), .req_valid_in(pv),
      .req_write_in(pw), .req_index_in(pidx), .req_value_in(pval), .ready_out(pready),
      .xfer_out(pxfer), .xfer_index_out(xidx), .xfer_value_out(xval));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
      @(posedge clk_in);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk_in);
      wr    <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [8:0] a);
      @(posedge clk_in);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk_in);
      rd   <= 1'b0;
      #1 rdat = rdata_out;
   endtask : rd_reg

   task automatic poll(input logic [31:0] mask, input logic [31:0] want);
      int n;
      n = 0;
      do
      begin
         rd_reg(lpt_pkg::OFS_PHY_CTRL);
         n++;
      end while (((rdat & mask) !== want) && n < 50);
      if (n >= 50) chk(rdat & mask, want);
   endtask : poll

   task automatic judge(input logic h, input logic [15:0] s, input logic e);
      @(posedge clk_in);
      rx_valid <= 1'b1;
      rx_hit   <= h;
      rx_src   <= s;
      @(posedge clk_in);
      rx_valid <= 1'b0;
      #1 chk(rx_done_out, 1'b1);
      chk(rx_accept_out, e);
   endtask : judge

   task automatic stop_test;
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   // Whole run is a few hundred cycles; this is far beyond it
   initial
   begin
      #400000;
      err_count++;
      stop_test();
   end

   initial
   begin
      repeat (2) @(posedge clk_in);
      reset_in <= 1'b0;
      rd_reg(lpt_pkg::OFS_FILT_SET);
      chk(rdat, lpt_pkg::FILT_RST);
      rd_reg(9'h1fc);
      chk(rdat, 32'h0);
      wr_reg(lpt_pkg::OFS_FILT_SET, 32'h8000_0005);
      rd_reg(lpt_pkg::OFS_FILT_CLR);
      chk(rdat, 32'h8000_0005);
      wr_reg(lpt_pkg::OFS_FILT_CLR, 32'h0000_0001);
      rd_reg(lpt_pkg::OFS_FILT_SET);
      chk(rdat, 32'h8000_0004);
      judge(1'b1, {10'h003, 6'd34}, 1'b1);
      judge(1'b1, {10'h003, 6'd32}, 1'b0);
      judge(1'b1, {10'h003, 6'd63}, 1'b0);
      judge(1'b1, {10'h003, 6'd3}, 1'b1);
      judge(1'b1, {10'h005, 6'd32}, 1'b1);
      judge(1'b0, {10'h003, 6'd32}, 1'b1);
      wr_reg(lpt_pkg::OFS_FILT_CLR, 32'h8000_0000);
      judge(1'b1, {10'h005, 6'd34}, 1'b0);
      // Phy read of index 3; model holds 0x43 there
      wr_reg(lpt_pkg::OFS_PHY_CTRL, 32'h0000_8305);
      poll(32'h8000_0000, 32'h8000_0000);
      chk(rdat, 32'h8343_0305);
      wr_reg(lpt_pkg::OFS_PHY_CTRL, 32'h0000_45a5);
      rd_reg(lpt_pkg::OFS_PHY_CTRL);
      chk(rdat[31], 1'b0);
      poll(32'h0000_4000, 32'h0);
      chk(lpt_phy_model_i.mem_r[5], 8'ha5);
      wr_reg(lpt_pkg::OFS_PHY_CTRL, 32'h0000_8511);
      poll(32'h8000_0000, 32'h8000_0000);
      chk(rdat, 32'h85a5_0511);
      // Timer wraps all three fields at once
      wr_reg(lpt_pkg::OFS_LINK_CFG, 32'h2);
      wr_reg(lpt_pkg::OFS_CYC_TIME, {7'h7f, lpt_pkg::CYC_LAST, 12'hbf0});
      repeat (200) @(posedge clk_in);
      rd_reg(lpt_pkg::OFS_CYC_TIME);
      chk(rdat[31:12], 20'h0);
      chk(rdat[11:0] >= 12'd16 && rdat[11:0] <= 12'd32, 1'b1);
      wr_reg(lpt_pkg::OFS_CYC_TIME, {7'd2, 13'd5, 12'hbfe});
      wr_reg(lpt_pkg::OFS_LINK_CFG, 32'h3);
      for (int n = 0; n < 100 && cs_tx_out !== 1'b1; n++) @(posedge clk_in) #1;
      chk(cs_tx_out, 1'b1);
      chk(cs_tx_data_out, {7'd2, 13'd6, 12'd0});
      wr_reg(lpt_pkg::OFS_LINK_CFG, 32'h0);
      @(posedge clk_in);
      cs_rx      <= 1'b1;
      cs_rx_data <= {7'd3, 13'd100, 12'd200};
      @(posedge clk_in);
      cs_rx      <= 1'b0;
      rd_reg(lpt_pkg::OFS_CYC_TIME);
      chk(rdat, {7'd3, 13'd100, 12'd200});
      wr_reg(lpt_pkg::OFS_LINK_CFG, 32'h6);
      wr_reg(lpt_pkg::OFS_CYC_TIME, {7'd0, 13'd10, 12'h100});
      ext_tick <= 1'b1;
      repeat (8) @(posedge clk_in);
      rd_reg(lpt_pkg::OFS_CYC_TIME);
      chk(rdat[31:12], {7'd0, 13'd11});
      chk(rdat[11:0] < 12'd8, 1'b1);
      ext_tick <= 1'b0;
      stop_test();
   end
endmodule : lpt_link_regs_tb
